// File: hw/rtst_pkg.sv
package rtst_pkg;
    // ==================================================
    // Register offsets and reset values
    localparam logic [7:0] OFS_TIMER_LIMIT    = 8'h12;
    localparam logic [7:0] OFS_TIMER_COUNT    = 8'h13;
    localparam logic [7:0] OFS_SUBTIMER_LIMIT = 8'h14;
    localparam logic [7:0] RST_BYTE           = 8'h00;
    localparam logic [6:0] SUB_START          = 7'h01;
    localparam logic [7:0] MIN_LIMIT          = 8'h02;
    localparam logic [7:0] SUB_MAX            = 8'h7F;
    // ==================================================
    // Default sub-timer limits per rate
    localparam logic [7:0] DEF_SUB_4K   = 8'h29;
    localparam logic [7:0] DEF_SUB_100  = 8'h64;
    localparam logic [7:0] DEF_SUB_SEC  = 8'h3C;
    localparam logic [7:0] DEF_SUB_MIN  = 8'h3C;
    // ==================================================
    // Encodings of rate and function selects
    localparam logic [1:0] RATE_4K   = 2'h0;
    localparam logic [1:0] RATE_100  = 2'h1;
    localparam logic [1:0] RATE_SEC  = 2'h2;
    localparam logic [1:0] RATE_MIN  = 2'h3;
    localparam logic [1:0] FN_DOWN   = 2'h0;
    localparam logic [1:0] FN_ALARM  = 2'h1;
    localparam logic [1:0] FN_WDOG   = 2'h2;
    localparam logic [1:0] FN_PFAIL  = 2'h3;
    // ==================================================
    // Interrupt pulse timing
    localparam int CLK_KHZ    = 250000;
    localparam int PULSE_MS   = 210;
    localparam int PULSE_CYC  = PULSE_MS * CLK_KHZ;
    localparam int PULSE_W    = 26;
    // ==================================================
    // Timer states, Gray coded along idle, arm, run, done
    typedef enum logic [1:0] {
        RTST_IDLE = 2'b00,
        RTST_ARM  = 2'b01,
        RTST_RUN  = 2'b11,
        RTST_DONE = 2'b10
    } rtst_state_e;
endpackage : rtst_pkg

// File: hw/rtst_timer.sv
`timescale 1ns/1ns
module rtst_timer #(
    parameter int unsigned PULSE_CYCLES = rtst_pkg::PULSE_CYC // Low pulse length in cycles
) (
    input  wire logic       clock,                 // 250 MHz clock
    input  wire logic       rst_n,                 // Synchronous reset, active low
    input  wire logic [7:0] reg_addr,              // Register address
    input  wire logic       reg_wr,                // Register write strobe
    input  wire logic [7:0] reg_wdata,             // Register write data
    input  wire logic       reg_rd,                // Register read strobe
    output logic      [7:0] reg_rdata,             // Registered read data
    input  wire logic [1:0] tick_rate_select,      // Tick rate select
    input  wire logic [1:0] count_function_select, // Counting function select
    input  wire logic       timer_run_enable,      // Timer run enable
    input  wire logic       pulse_mode_select,     // 1 pulse, 0 held low except watchdog, which always pulses
    input  wire logic       second_irq_enable,     // Interrupt pin enable
    input  wire logic       timer_flag_clear,      // Pulse: clear expired flag
    input  wire logic       alarm_match_flag,      // Alarm match status level
    input  wire logic       on_battery,            // Running from battery
    input  wire logic       rtc_running,           // Clock oscillator running
    input  wire logic       tick_4khz,             // 4kHz tick pulse
    input  wire logic       tick_100hz,            // 100Hz tick pulse
    input  wire logic       tick_1s,               // 1s tick pulse
    input  wire logic       tick_1min,             // 1min tick pulse
    output logic            timer_expired_flag,    // Sticky expired flag
    output logic            second_irq_n           // Interrupt pin, active low
);
    import rtst_pkg::*;

    // ==================================================
    // State record
    typedef struct packed {
        rtst_state_e         state;
        logic [7:0]          limit;     // Main counter start value counting down, end value counting up
        logic [7:0]          sublimit;  // Sub-timer end value, write only
        logic [7:0]          count;     // Main counter
        logic [6:0]          sub;       // Sub-timer, no register path
        logic                flag;
        logic                hold;      // Single-event low level held
        logic [PULSE_W-1:0]  pulse_cnt;
        logic                en_d;
        logic                alm_d;
        logic                irq_n;
        logic [7:0]          rdata;
    } rtst_regs_s;

    rtst_regs_s r_reg;
    rtst_regs_s r_next;

    logic       down;
    logic       periodic;
    logic       tick;
    logic       tick_ok;
    logic [7:0] sub_end;
    logic       ovf;
    logic       expire;
    logic       reload;
    logic [7:0] step_count;

    // ==================================================
    // Tick selection and gating
    always_comb begin
        down     = (count_function_select == FN_DOWN) ||
                   (count_function_select == FN_ALARM);
        periodic = pulse_mode_select || (count_function_select == FN_WDOG);
        case (tick_rate_select)
            RATE_4K: begin
                tick    = tick_4khz;
                sub_end = DEF_SUB_4K;
            end
            RATE_100: begin
                tick    = tick_100hz;
                sub_end = DEF_SUB_100;
            end
            RATE_SEC: begin
                tick    = tick_1s & rtc_running;
                sub_end = DEF_SUB_SEC;
            end
            default: begin
                tick    = tick_1min & rtc_running;
                sub_end = DEF_SUB_MIN;
            end
        endcase
        // Zero limit falls back to the rate default
        if (r_reg.sublimit != RST_BYTE) begin
            sub_end = r_reg.sublimit;
        end
        // Watchdog cannot run from the fastest rate; power-fail waits for battery
        tick_ok = tick
                  && !((count_function_select == FN_WDOG) && (tick_rate_select == RATE_4K))
                  && !((count_function_select == FN_PFAIL) && !on_battery);
    end

    // ==================================================
    // Counting step and expiry detection
    always_comb begin
        ovf        = (r_reg.state == RTST_RUN) && tick_ok && ({1'b0, r_reg.sub} >= sub_end);
        step_count = down ? r_reg.count - 8'h01 : r_reg.count + 8'h01;
        expire     = ovf && (down ? (step_count == RST_BYTE)
                                  : (step_count == r_reg.limit));
        reload     = timer_flag_clear && r_reg.flag && !expire &&
                     (r_reg.state != RTST_IDLE) && timer_run_enable;
    end

    // ==================================================
    // Next-state logic
    always_comb begin
        r_next       = r_reg;
        r_next.en_d  = timer_run_enable;
        r_next.alm_d = alarm_match_flag;
        // Register writes; the count register takes none
        if (reg_wr) begin
            if (reg_addr == OFS_TIMER_LIMIT) begin
                r_next.limit = reg_wdata;
            end else if (reg_addr == OFS_SUBTIMER_LIMIT) begin
                r_next.sublimit = reg_wdata;
            end
        end
        // Register reads; sub-timer limit always reads zero
        if (reg_rd) begin
            if (reg_addr == OFS_TIMER_LIMIT) begin
                r_next.rdata = r_reg.limit;
            end else if (reg_addr == OFS_TIMER_COUNT) begin
                r_next.rdata = r_reg.count;
            end else begin
                r_next.rdata = RST_BYTE;
            end
        end
        if (r_reg.pulse_cnt != '0) begin
            r_next.pulse_cnt = r_reg.pulse_cnt - 1'b1;
        end
        if (!timer_run_enable) begin
            // Stopped: clean counters, pin released, flag kept
            r_next.state     = RTST_IDLE;
            r_next.count     = RST_BYTE;
            r_next.sub       = SUB_START;
            r_next.hold      = 1'b0;
            r_next.pulse_cnt = '0;
        end else begin
            case (r_reg.state)
                RTST_IDLE: begin
                    // Only a fresh enable starts; a low limit needs re-enable
                    if (!r_reg.en_d && (r_reg.limit >= MIN_LIMIT)) begin
                        r_next.count = down ? r_reg.limit : 8'h01;
                        r_next.sub   = SUB_START;
                        r_next.state = (count_function_select == FN_ALARM) ?
                                       RTST_ARM : RTST_RUN;
                    end
                end
                RTST_ARM: begin
                    if (alarm_match_flag && !r_reg.alm_d) begin
                        r_next.state = RTST_RUN;
                    end
                end
                RTST_RUN: begin
                    if (ovf) begin
                        r_next.sub   = SUB_START;
                        r_next.count = step_count;
                    end else if (tick_ok) begin
                        r_next.sub = r_reg.sub + 7'h01;
                    end
                    if (expire) begin
                        if (periodic) begin
                            r_next.count     = down ? r_reg.limit : 8'h01;
                            r_next.pulse_cnt = PULSE_W'(PULSE_CYCLES);
                        end else begin
                            r_next.state = RTST_DONE;
                            r_next.hold  = 1'b1;
                        end
                    end
                end
                default: begin
                end
            endcase
            // Clearing the flag starts a fresh cycle
            if (reload) begin
                r_next.count = down ? r_reg.limit : 8'h01;
                r_next.sub   = SUB_START;
                r_next.state = RTST_RUN;
                r_next.hold  = 1'b0;
            end
        end
        // Expiry wins over a clear in the same cycle
        if (expire) begin
            r_next.flag = 1'b1;
        end else if (timer_flag_clear) begin
            r_next.flag = 1'b0;
        end
        r_next.irq_n = !(second_irq_enable &&
                         (r_next.hold || (r_next.pulse_cnt != '0)));
    end

    // ==================================================
    // State register
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            r_reg           <= '0;
            r_reg.state     <= RTST_IDLE;
            r_reg.sub       <= SUB_START;
            r_reg.irq_n     <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    assign reg_rdata          = r_reg.rdata;
    assign timer_expired_flag = r_reg.flag;
    assign second_irq_n       = r_reg.irq_n;

    // ==================================================
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    logic [3:0] low_run;
    always_ff @(posedge clock) begin
        if (!rst_n || second_irq_n) begin
            low_run <= 4'h0;
        end else if (low_run != 4'hF) begin
            low_run <= low_run + 4'h1;
        end
    end

    sequence start_down_s;
        timer_run_enable && !r_reg.en_d && r_reg.state == RTST_IDLE
        && r_reg.limit >= MIN_LIMIT && down;
    endsequence

    sequence expire_pulse_s;
        expire && pulse_mode_select && second_irq_enable && timer_run_enable;
    endsequence

    sub_read_zero_a: assert property (
        reg_rd && reg_addr == OFS_SUBTIMER_LIMIT |=> reg_rdata == RST_BYTE)
        else $error("sub-timer limit did not read zero");
    limit_store_a: assert property (
        reg_wr && reg_addr == OFS_TIMER_LIMIT ##1 reg_rd && reg_addr == OFS_TIMER_LIMIT
        && !(reg_wr && reg_addr == OFS_TIMER_LIMIT) |=> reg_rdata == $past(reg_wdata, 2))
        else $error("timer limit readback wrong");
    idle_clean_a: assert property (
        !timer_run_enable |=> r_reg.count == RST_BYTE && r_reg.sub == SUB_START)
        else $error("disabled counters not clean");
    enable_load_a: assert property (
        start_down_s |=> r_reg.count == $past(r_reg.limit) && r_reg.sub == SUB_START)
        else $error("enable load wrong");
    expire_flag_a: assert property (
        expire |=> timer_expired_flag)
        else $error("expiry did not set flag");
    irq_gate_a: assert property (
        !second_irq_enable |=> second_irq_n)
        else $error("interrupt pin low while disabled");
    pulse_low_a: assert property (
        expire_pulse_s ##1 (timer_run_enable && second_irq_enable)[*8]
        |-> $past(second_irq_n, 7) == 1'b0 || low_run >= 4'h7)
        else $error("pulse not held low");
    hold_low_a: assert property (
        r_reg.state == RTST_DONE && second_irq_enable && timer_run_enable
        && !timer_flag_clear |=> !second_irq_n)
        else $error("single event pin released early");
    sub_bound_a: assert property (
        r_reg.state == RTST_RUN |-> {1'b0, r_reg.sub} <= sub_end)
        else $error("sub-timer beyond its end value");
    overflow_step_a: assert property (
        ovf && timer_run_enable && !reload |=> r_reg.sub == SUB_START)
        else $error("overflow did not reload sub-timer");
    wdog_slow_a: assert property (
        count_function_select == FN_WDOG && tick_rate_select == RATE_4K |-> !tick_ok)
        else $error("watchdog ran at fastest rate");
endmodule : rtst_timer

// File: tb/rtst_timebase.sv
`timescale 1ns/1ns
module rtst_timebase (
    input  wire logic       clock,      // Bench clock
    input  wire logic       rst_n,      // Synchronous reset, active low
    input  wire logic [3:0] fire,       // One request bit per tick line
    output logic            tick_4khz,  // 4kHz tick pulse
    output logic            tick_100hz, // 100Hz tick pulse
    output logic            tick_1s,    // 1s tick pulse
    output logic            tick_1min   // 1min tick pulse
);
    // ==================================================
    // Time base
    // Registered so a tick never changes on the edge that samples it
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            {tick_1min, tick_1s, tick_100hz, tick_4khz} <= 4'h0;
        end else begin
            {tick_1min, tick_1s, tick_100hz, tick_4khz} <= fire;
        end
    end
endmodule : rtst_timebase

// File: tb/rtst_timer_tb.sv
`timescale 1ns/1ns
module rtst_timer_tb;
    import rtst_pkg::*;
    localparam int PULSE_LEN = 20; // Short pulse keeps the run brief
    logic       clock, rst_n, reg_wr, reg_rd, timer_run_enable, pulse_mode_select;
    logic       second_irq_enable, timer_flag_clear, alarm_match_flag, on_battery;
    logic       rtc_running, timer_expired_flag, second_irq_n;
    logic       tick_4khz, tick_100hz, tick_1s, tick_1min;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [1:0] tick_rate_select, count_function_select;
    logic [3:0] fire;
    logic [7:0] defs [4];
    int         fails, comparisons, low_cnt, n;

    rtst_timer #(.PULSE_CYCLES(PULSE_LEN)) dut (
        .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .tick_rate_select(tick_rate_select), .count_function_select(count_function_select),
        .timer_run_enable(timer_run_enable), .pulse_mode_select(pulse_mode_select),
        .second_irq_enable(second_irq_enable), .timer_flag_clear(timer_flag_clear),
        .alarm_match_flag(alarm_match_flag), .on_battery(on_battery),
        .rtc_running(rtc_running), .tick_4khz(tick_4khz), .tick_100hz(tick_100hz),
        .tick_1s(tick_1s), .tick_1min(tick_1min),
        .timer_expired_flag(timer_expired_flag), .second_irq_n(second_irq_n));

    rtst_timebase timebase (
        .clock(clock), .rst_n(rst_n), .fire(fire), .tick_4khz(tick_4khz),
        .tick_100hz(tick_100hz), .tick_1s(tick_1s), .tick_1min(tick_1min));

    // ==================================================
    // Clock and pulse width monitor
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    always @(posedge clock) if (second_irq_n === 1'b0) low_cnt <= low_cnt + 1;

    // ==================================================
    // Access tasks
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr    <= 1'b0;
    endtask : wr
    // Data lands on the read edge and holds, so look just after it
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd   <= 1'b0;
        #1;
        check($sformatf("register %h", a), reg_rdata, exp);
    endtask : rd_chk
    task automatic pins_chk(input logic f, input logic p);
        check("expired flag", {7'h00, timer_expired_flag}, {7'h00, f});
        check("interrupt pin", {7'h00, second_irq_n}, {7'h00, p});
    endtask : pins_chk
    task automatic tick(input int idx, input int cnt);
        repeat (cnt) begin
            @(posedge clock);
            fire[idx] <= 1'b1;
            @(posedge clock);
            fire <= 4'h0;
        end
        repeat (3) @(posedge clock);
        #1;
    endtask : tick
    task automatic cfg(input logic [1:0] r, input logic [1:0] f, input logic p, input logic i);
        @(posedge clock);
        tick_rate_select      <= r;
        count_function_select <= f;
        pulse_mode_select     <= p;
        second_irq_enable     <= i;
    endtask : cfg
    task automatic en(input logic v);
        @(posedge clock);
        timer_run_enable <= v;
        repeat (2) @(posedge clock);
    endtask : en
    task automatic clr();
        @(posedge clock);
        timer_flag_clear <= 1'b1;
        @(posedge clock);
        timer_flag_clear <= 1'b0;
        repeat (2) @(posedge clock);
        #1;
    endtask : clr
    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run

    // ==================================================
    // Watchdog, far beyond the thousand or so cycles the tests need
    initial begin
        repeat (40000) @(posedge clock);
        fails++;
        complete_run();
    end

    // ==================================================
    // Test sequence
    initial begin
        {rst_n, reg_wr, reg_rd, timer_run_enable, pulse_mode_select} = 5'h00;
        {second_irq_enable, timer_flag_clear, alarm_match_flag, on_battery} = 4'h0;
        {rtc_running, reg_addr, reg_wdata, fire} = 21'h0;
        {tick_rate_select, count_function_select} = 4'h0;
        {fails, comparisons, low_cnt} = 0;
        defs = '{DEF_SUB_4K, DEF_SUB_100, DEF_SUB_SEC, DEF_SUB_MIN};
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        #1;
        pins_chk(1'b0, 1'b1);
        rd_chk(OFS_TIMER_LIMIT, RST_BYTE);
        rd_chk(OFS_TIMER_COUNT, RST_BYTE);
        rd_chk(OFS_SUBTIMER_LIMIT, RST_BYTE);
        $display("test reset done");
        wr(OFS_TIMER_LIMIT, 8'h05);
        rd_chk(OFS_TIMER_LIMIT, 8'h05);
        // Write then read on the next edge sees the new value
        @(posedge clock);
        reg_addr  <= OFS_TIMER_LIMIT;
        reg_wdata <= 8'h07;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b1;
        @(posedge clock);
        reg_rd    <= 1'b0;
        #1;
        check("limit back to back", reg_rdata, 8'h07);
        wr(OFS_TIMER_COUNT, 8'hAA);
        rd_chk(OFS_TIMER_COUNT, 8'h00);
        wr(OFS_SUBTIMER_LIMIT, SUB_MAX);
        rd_chk(OFS_SUBTIMER_LIMIT, 8'h00);
        rd_chk(8'h15, 8'h00);
        $display("test registers done");
        // Default limits per rate; the seconds rate first with the clock stopped
        wr(OFS_SUBTIMER_LIMIT, 8'h00);
        wr(OFS_TIMER_LIMIT, MIN_LIMIT);
        cfg(RATE_SEC, FN_DOWN, 1'b0, 1'b1);
        en(1'b1);
        tick(2, 60);
        rd_chk(OFS_TIMER_COUNT, 8'h02);
        en(1'b0);
        rtc_running <= 1'b1;
        for (int r = 0; r < 4; r++) begin
            cfg(r[1:0], FN_DOWN, 1'b0, 1'b1);
            en(1'b1);
            tick(r, int'(defs[r]) - 1);
            rd_chk(OFS_TIMER_COUNT, 8'h02);
            tick(r, 1);
            rd_chk(OFS_TIMER_COUNT, 8'h01);
            en(1'b0);
            rd_chk(OFS_TIMER_COUNT, 8'h00);
        end
        cfg(RATE_4K, FN_WDOG, 1'b0, 1'b1);
        en(1'b1);
        tick(0, 41);
        rd_chk(OFS_TIMER_COUNT, 8'h01);
        en(1'b0);
        $display("test rates done");
        // Single event count down, limit 3 and two ticks per step
        wr(OFS_SUBTIMER_LIMIT, 8'h02);
        wr(OFS_TIMER_LIMIT, 8'h03);
        cfg(RATE_100, FN_DOWN, 1'b0, 1'b1);
        en(1'b1);
        rd_chk(OFS_TIMER_COUNT, 8'h03);
        tick(1, 5);
        rd_chk(OFS_TIMER_COUNT, 8'h01);
        pins_chk(1'b0, 1'b1);
        tick(1, 1);
        pins_chk(1'b1, 1'b0);
        tick(1, 4);
        pins_chk(1'b1, 1'b0);
        rd_chk(OFS_TIMER_COUNT, 8'h00);
        clr();
        pins_chk(1'b0, 1'b1);
        rd_chk(OFS_TIMER_COUNT, 8'h03);
        en(1'b0);
        cfg(RATE_100, FN_DOWN, 1'b0, 1'b0);
        en(1'b1);
        tick(1, 6);
        pins_chk(1'b1, 1'b1);
        en(1'b0);
        clr();
        $display("test single event done");
        // Alarm started count down waits for the alarm flag
        cfg(RATE_100, FN_ALARM, 1'b0, 1'b1);
        en(1'b1);
        tick(1, 6);
        rd_chk(OFS_TIMER_COUNT, 8'h03);
        @(posedge clock);
        alarm_match_flag <= 1'b1;
        tick(1, 6);
        pins_chk(1'b1, 1'b0);
        en(1'b0);
        clr();
        alarm_match_flag <= 1'b0;
        // Power fail count up only on battery
        cfg(RATE_100, FN_PFAIL, 1'b0, 1'b1);
        en(1'b1);
        tick(1, 6);
        rd_chk(OFS_TIMER_COUNT, 8'h01);
        @(posedge clock);
        on_battery <= 1'b1;
        tick(1, 4);
        pins_chk(1'b1, 1'b0);
        en(1'b0);
        clr();
        $display("test functions done");
        // Watchdog with pulses, then a limit too small to run
        cfg(RATE_100, FN_WDOG, 1'b1, 1'b1);
        en(1'b1);
        rd_chk(OFS_TIMER_COUNT, 8'h01);
        low_cnt = 0;
        tick(1, 4);
        pins_chk(1'b1, 1'b0);
        for (n = 0; n < 100 && second_irq_n !== 1'b1; n++) begin
            @(posedge clock);
            #1;
        end
        check("pulse cycles", low_cnt[7:0], PULSE_LEN[7:0]);
        rd_chk(OFS_TIMER_COUNT, 8'h01);
        en(1'b0);
        clr();
        wr(OFS_TIMER_LIMIT, 8'h01);
        cfg(RATE_100, FN_DOWN, 1'b0, 1'b1);
        en(1'b1);
        tick(1, 4);
        rd_chk(OFS_TIMER_COUNT, 8'h00);
        pins_chk(1'b0, 1'b1);
        $display("test watchdog done");
        complete_run();
    end
endmodule : rtst_timer_tb
